// ---- design/fifo_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fifo_host_params.svh"

module fifo_host #(
    parameter int DEPTH = `DEPTH_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [`WORD_W-1:0] din,
    output logic wr_n,
    output logic rd_n,
    output logic clear_in_n,
    output logic replay_n,
    output logic chain_in_n,
    input wire logic [`WORD_W-1:0] dout,
    input wire logic empty_ind_n,
    input wire logic full_ind_n,
    input wire logic half_level_ind_n
);

    localparam logic [7:0] C_RSS = 8'(`CYC(`T_RSS_NS));
    localparam logic [7:0] C_RSW = 8'(`CYC(`T_RSW_NS));
    localparam logic [7:0] C_RSR = 8'(`CYC(`T_RSR_NS));
    localparam logic [7:0] C_WLOW = 8'(`CYC(`T_WLOW_NS));
    localparam logic [7:0] C_RLOW = 8'(`CYC(`T_RLOW_NS));
    localparam logic [7:0] C_REC = 8'(`CYC(`T_REC_NS));
    localparam logic [7:0] C_RTW = 8'(`CYC(`T_RTW_NS));
    localparam int CW = $clog2(DEPTH) + 2;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    fifo_host_pkg::state_t state;
    fifo_host_pkg::flags_t flags;
    logic [7:0] cnt;
    logic [`WORD_W-1:0] dout_s;
    logic [`WORD_W-1:0] rdata;
    logic [CW-1:0] wr_count;
    logic cleared;
    logic error;

    pin_sync #(
        .WIDTH(`WORD_W + 3)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin({half_level_ind_n, full_ind_n, empty_ind_n, dout}),
        .sync({flags, dout_s})
    );

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] reg_off);
        hit = (addr == reg_off);
    endfunction : hit

    logic idle;
    logic wr_take;
    logic cmd_data;
    logic cmd_ctrl;
    logic go_clear;
    logic go_replay;
    logic go_read;
    logic ok_write;
    logic ok_replay;
    logic ok_read;

    assign idle = (state == fifo_host_pkg::st_idle);
    // writes wait while a pin sequence runs; reads are always served
    assign wr_take = avs_write && avs_waitrequest && idle;
    assign cmd_data = wr_take && hit(avs_address, `REG_WDATA);
    assign cmd_ctrl = wr_take && hit(avs_address, `REG_CTRL);
    assign go_clear = cmd_ctrl && avs_writedata[`CTRL_CLEAR];
    assign go_replay = cmd_ctrl && !avs_writedata[`CTRL_CLEAR] && avs_writedata[`CTRL_REPLAY];
    assign go_read = cmd_ctrl && !avs_writedata[`CTRL_CLEAR] && !avs_writedata[`CTRL_REPLAY]
        && avs_writedata[`CTRL_READ];
    assign ok_write = cleared && flags.full_n; // R3
    assign ok_read = cleared && flags.empty_n;
    assign ok_replay = cleared && (wr_count <= DEPTH_C); // R20

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if ((avs_read || (avs_write && idle)) && avs_waitrequest)
        begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            if (avs_read && hit(avs_address, `REG_STATUS))
            begin
                avs_readdata[`ST_EMPTY_N] <= flags.empty_n;
                avs_readdata[`ST_FULL_N] <= flags.full_n;
                avs_readdata[`ST_HALF_N] <= flags.half_n;
                avs_readdata[`ST_BUSY] <= !idle;
                avs_readdata[`ST_CLEARED] <= cleared;
                avs_readdata[`ST_ERROR] <= error;
            end
            else if (avs_read && hit(avs_address, `REG_RDATA))
            begin
                avs_readdata[`WORD_W-1:0] <= rdata;
            end
        end
        else
        begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= fifo_host_pkg::st_idle;
            cnt <= 8'h00;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            clear_in_n <= 1'b1;
            replay_n <= 1'b1;
            din <= `DIN_RESET;
            rdata <= `DIN_RESET;
        end
        else
        begin
            case (state)
                fifo_host_pkg::st_idle:
                begin
                    if (cmd_data && ok_write)
                    begin
                        din <= avs_writedata[`WORD_W-1:0]; // R1
                        wr_n <= 1'b0;
                        cnt <= C_WLOW - 8'h01;
                        state <= fifo_host_pkg::st_wr_low;
                    end
                    else if (go_clear)
                    begin
                        cnt <= C_RSS - 8'h01; // R4
                        state <= fifo_host_pkg::st_clr_setup;
                    end
                    else if (go_replay && ok_replay)
                    begin
                        replay_n <= 1'b0; // R19
                        cnt <= C_RTW - 8'h01;
                        state <= fifo_host_pkg::st_rt_low;
                    end
                    else if (go_read && ok_read)
                    begin
                        rd_n <= 1'b0;
                        cnt <= C_RLOW - 8'h01;
                        state <= fifo_host_pkg::st_rd_low;
                    end
                end
                fifo_host_pkg::st_clr_setup:
                begin
                    if (cnt == 8'h00)
                    begin
                        clear_in_n <= 1'b0; // R3
                        cnt <= C_RSW - 8'h01;
                        state <= fifo_host_pkg::st_clr_low;
                    end
                    else
                    begin
                        cnt <= cnt - 8'h01;
                    end
                end
                fifo_host_pkg::st_clr_low:
                begin
                    if (cnt == 8'h00)
                    begin
                        clear_in_n <= 1'b1;
                        cnt <= C_RSR - 8'h01; // R4
                        state <= fifo_host_pkg::st_clr_rec;
                    end
                    else
                    begin
                        cnt <= cnt - 8'h01;
                    end
                end
                fifo_host_pkg::st_wr_low,
                fifo_host_pkg::st_rd_low,
                fifo_host_pkg::st_rt_low:
                begin
                    if (cnt == 8'h00)
                    begin
                        // data sampled late in the low phase to cover access and sync
                        if (state == fifo_host_pkg::st_rd_low)
                        begin
                            rdata <= dout_s;
                        end
                        wr_n <= 1'b1;
                        rd_n <= 1'b1;
                        replay_n <= 1'b1;
                        cnt <= C_REC - 8'h01;
                        state <= fifo_host_pkg::st_rec;
                    end
                    else
                    begin
                        cnt <= cnt - 8'h01;
                    end
                end
                fifo_host_pkg::st_clr_rec,
                fifo_host_pkg::st_rec:
                begin
                    // recovery also lets the synced flags settle before the next strobe
                    if (cnt == 8'h00)
                    begin
                        state <= fifo_host_pkg::st_idle;
                    end
                    else
                    begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default:
                begin
                    state <= fifo_host_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cleared <= 1'b0;
            error <= 1'b0;
            wr_count <= '0;
            chain_in_n <= 1'b0; // R16
        end
        else
        begin
            chain_in_n <= 1'b0; // R21
            if (go_clear)
            begin
                cleared <= 1'b0;
                error <= 1'b0;
                wr_count <= '0;
            end
            else
            begin
                if (state == fifo_host_pkg::st_clr_low && cnt == 8'h00)
                begin
                    cleared <= 1'b1;
                end
                if ((cmd_data && !ok_write) || (go_read && !ok_read)
                    || (go_replay && !ok_replay))
                begin
                    error <= 1'b1;
                end
                if (cmd_data && ok_write && wr_count <= DEPTH_C)
                begin
                    wr_count <= wr_count + CW'(1); // R20
                end
            end
        end
    end

    sequence clr_recovery;
        (wr_n && rd_n)[*4];
    endsequence

    chk_write_after_clear: assert property (@(posedge clk) disable iff (!arst_n)
        !cleared |-> wr_n) // R3
        else $error("write strobe before clear");
    chk_clear_strobes_high: assert property (@(posedge clk) disable iff (!arst_n)
        !clear_in_n |-> (wr_n && rd_n)) // R4
        else $error("strobe low during clear");
    chk_clear_recovery: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(clear_in_n) |-> clr_recovery) // R4
        else $error("strobe moved within clear recovery");
    chk_replay_strobes: assert property (@(posedge clk) disable iff (!arst_n)
        !replay_n |-> (wr_n && rd_n && clear_in_n)) // R19
        else $error("strobe low during replay");
    chk_replay_depth: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(replay_n) |-> (wr_count <= DEPTH_C)) // R20
        else $error("replay after too many writes");
    chk_write_room: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(wr_n) |-> $past(flags.full_n)) // R23
        else $error("write strobe while full");
    chk_read_data: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(rd_n) |-> $past(flags.empty_n) ##1 !rd_n[*2]) // R23
        else $error("bad read strobe");
    chk_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("read not answered next cycle");

endmodule : fifo_host

`default_nettype wire

// ---- design/fifo_host_params.svh ----
// Overview of operation
// R1: data moves as 9-bit words, no addressing
// R2: clear low resets both device pointers
// R3: controller clears before any write or read
// R4: strobes high around clear, held for recovery
// R5: device half-level indicator high after clear
// R6: device writes on write falling edge, not full
// R7: half-level indicator tracks pointer difference
// R8: full indicator low when buffer full
// R9: full device ignores write strobe
// R10: full released after valid read
// R11: device reads on read falling edge, not empty
// R12: device outputs float while read strobe high
// R13: empty indicator low when pointers equal
// R14: empty released after valid write
// R15: empty device ignores read strobe
// R16: chain input low selects single-device mode
// R17: grounded load pin marks first chain device
// R18: replay pulse rewinds read pointer only
// R19: strobes held high during whole replay pulse
// R20: replay only if writes since clear within depth
// R21: no replay in depth-chain mode
// R22: chain output pulses at last location
// R23: pointers advance only while flag inactive
// R24: pointers wrap circularly to first location
`ifndef FIFO_HOST_PARAMS_SVH
`define FIFO_HOST_PARAMS_SVH

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_WDATA 4'h8
`define REG_RDATA 4'hc

`define CTRL_CLEAR 0
`define CTRL_REPLAY 1
`define CTRL_READ 2

`define ST_EMPTY_N 0
`define ST_FULL_N 1
`define ST_HALF_N 2
`define ST_BUSY 3
`define ST_CLEARED 4
`define ST_ERROR 5

`define DEPTH_DEFAULT 512
`define WORD_W 9
`define DIN_RESET 9'h000

`define TCLK_NS 8
`define T_RSS_NS 30
`define T_RSW_NS 50
`define T_RSR_NS 40
`define T_WLOW_NS 60
`define T_RLOW_NS 80
`define T_REC_NS 40
`define T_RTW_NS 50
// least times, rounded up to whole cycles
`define CYC(ns) (((ns) + `TCLK_NS - 1) / `TCLK_NS)

`endif

// ---- design/fifo_host_pkg.sv ----
package fifo_host_pkg;

    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_clr_setup = 4'h1,
        st_clr_low = 4'h2,
        st_clr_rec = 4'h3,
        st_wr_low = 4'h4,
        st_rd_low = 4'h5,
        st_rt_low = 4'h6,
        st_rec = 4'h7
    } state_t;

    typedef struct packed {
        logic half_n;
        logic full_n;
        logic empty_n;
    } flags_t;

endpackage : fifo_host_pkg

// ---- design/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);

    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // first stage is read only by the second
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    meta[i] <= 1'b0;
                    sync[i] <= 1'b0;
                end
                else
                begin
                    meta[i] <= pin[i];
                    sync[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ---- verification/fifo_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module fifo_dev_model #(
    parameter int DEPTH = 8
) (
    input wire logic [8:0] din,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic clear_in_n,
    input wire logic replay_n,
    input wire logic chain_in_n,
    output logic [8:0] dout,
    output logic empty_ind_n,
    output logic full_ind_n,
    output logic half_level_ind_n,
    output int misuse
);
    logic [8:0] mem [DEPTH];
    int wcnt = 0;
    int rcnt = 0;
    int lvl;
    logic armed = 1'b0;
    logic wgo = 1'b0;
    logic rgo = 1'b0;
    realtime t_rise = -1000.0;
    initial dout = 9'h0aa;
    initial misuse = 0;
    assign lvl = wcnt - rcnt;
    // counts move at strobe rise, so flags release once a transfer completes
    assign empty_ind_n = (lvl != 0);
    assign full_ind_n = (lvl < DEPTH);
    // shared pin: chain pulse at the last location once chained
    assign half_level_ind_n = chain_in_n ? !(wgo && (wcnt % DEPTH == DEPTH - 1))
        : (lvl <= DEPTH / 2);
    always @(negedge wr_n or posedge wr_n or negedge clear_in_n)
        if (!clear_in_n)
        begin
            wcnt <= 0;
            armed <= 1'b1;
            wgo <= 1'b0;
        end
        else if (!wr_n)
            wgo <= armed && full_ind_n;
        else if (wgo)
        begin
            mem[wcnt % DEPTH] <= din;
            wcnt <= wcnt + 1;
            wgo <= 1'b0;
        end
    always @(negedge rd_n or posedge rd_n or negedge clear_in_n or negedge replay_n)
        if (!clear_in_n)
        begin
            rcnt <= 0;
            rgo <= 1'b0;
        end
        else if (!replay_n)
        begin
            // chained: the pin only marks the first device
            if (!chain_in_n)
                rcnt <= 0;
        end
        else if (!rd_n)
        begin
            rgo <= empty_ind_n;
            if (empty_ind_n)
                dout <= mem[rcnt % DEPTH];
        end
        else
        begin
            if (rgo)
                rcnt <= rcnt + 1;
            rgo <= 1'b0;
            // released bus shows inverted value, never the held word
            dout <= ~dout;
        end
    always @(posedge clear_in_n)
        t_rise = $realtime;
    always @(negedge wr_n or negedge rd_n or negedge replay_n)
    begin
        if ((!wr_n || !rd_n) && (!replay_n || !clear_in_n))
            misuse++;
        if ($realtime - t_rise < 40.0)
            misuse++;
        if (!wr_n && !armed)
            misuse++;
        if (!replay_n && wcnt > DEPTH)
            misuse++;
    end
endmodule : fifo_dev_model

`default_nettype wire

// ---- verification/fifo_host_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module fifo_host_tb;
    localparam int DEPTH = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [8:0] din;
    logic [8:0] dout;
    logic wr_n, rd_n, clear_in_n, replay_n, chain_in_n;
    logic empty_ind_n, full_ind_n, half_level_ind_n;
    int misuse;
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic [8:0] exp_q [$];
    logic [8:0] hist [$];

    always #4 clk = ~clk;

    fifo_host #(.DEPTH(DEPTH)) dut_u (.clk(clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .din(din), .wr_n(wr_n), .rd_n(rd_n),
        .clear_in_n(clear_in_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
        .dout(dout), .empty_ind_n(empty_ind_n), .full_ind_n(full_ind_n),
        .half_level_ind_n(half_level_ind_n));

    fifo_dev_model #(.DEPTH(DEPTH)) dev_u (.din(din), .wr_n(wr_n), .rd_n(rd_n),
        .clear_in_n(clear_in_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
        .dout(dout), .empty_ind_n(empty_ind_n), .full_ind_n(full_ind_n),
        .half_level_ind_n(half_level_ind_n), .misuse(misuse));

    task stop_test;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task chk(input string what, input logic [31:0] e, input logic [31:0] got);
        cmp_count++;
        if (got !== e)
        begin
            $display("FAIL %s expected %h seen %h", what, e, got);
            bad_count++;
        end
    endtask : chk

    task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100)
        begin
            $display("FAIL waitrequest expected 0 seen 1");
            bad_count++;
        end
        @(posedge clk);
    endtask : bus

    task st(input logic [5:0] e);
        bus(1'b1, 4'h4, 32'h0);
        chk("status", {26'h0, e}, {26'h0, q[5:0]});
    endtask : st

    // busy polling; a stuck busy shows up as a failed compare
    task idle;
        int n;
        n = 0;
        q = 32'h8;
        while (q[3] !== 1'b0 && n < 100)
        begin
            bus(1'b1, 4'h4, 32'h0);
            n++;
        end
        chk("busy", 32'h0, {31'h0, q[3]});
    endtask : idle

    task cmd(input logic [3:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
        idle();
    endtask : cmd

    task put(input logic [8:0] d);
        cmd(4'h8, {23'h0, d});
        exp_q.push_back(d);
        hist.push_back(d);
    endtask : put

    task take;
        cmd(4'h0, 32'h4);
        bus(1'b1, 4'hc, 32'h0);
        chk("rdata", {23'h0, exp_q.pop_front()}, {23'h0, q[8:0]});
    endtask : take

    task clr;
        cmd(4'h0, 32'h1);
        exp_q = {};
        hist = {};
    endtask : clr

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        st(6'h06);
        cmd(4'h8, 32'h155);
        st(6'h26);
        bus(1'b1, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test before clear done");
        clr();
        st(6'h16);
        for (int i = 0; i < DEPTH; i++)
        begin
            put(9'h100 | 9'(i * 37));
            if (i == DEPTH / 2 - 1)
                st(6'h17);
            if (i == DEPTH / 2)
                st(6'h13);
        end
        st(6'h11);
        cmd(4'h8, 32'h0aa);
        st(6'h31);
        take();
        st(6'h33);
        take();
        $display("test fill done");
        cmd(4'h0, 32'h2);
        exp_q = hist;
        st(6'h31);
        for (int i = 0; i < DEPTH; i++)
            take();
        st(6'h36);
        cmd(4'h0, 32'h4);
        bus(1'b1, 4'hc, 32'h0);
        chk("rdata", {23'h0, hist[DEPTH - 1]}, {23'h0, q[8:0]});
        $display("test replay done");
        clr();
        st(6'h16);
        for (int i = 0; i < DEPTH; i++)
            put(~9'(i * 51));
        take();
        take();
        put(9'h0c3);
        put(9'h13c);
        for (int i = 0; i < DEPTH; i++)
            take();
        cmd(4'h0, 32'h2);
        st(6'h36);
        chk("misuse", 32'h0, misuse);
        chk("chain", 32'h0, {31'h0, chain_in_n});
        // all command bits at once: clear takes priority and wipes the error
        cmd(4'h0, 32'h7);
        st(6'h16);
        $display("test wrap done");
        stop_test();
    end

    initial
    begin
        #400000;
        bad_count++;
        stop_test();
    end
endmodule : fifo_host_tb

`default_nettype wire
